// file: common/aiss_pkg.sv
// Purpose: Shared constants for the analog input scan sequencer.
// Assumes: 32-bit register port with byte offsets on word boundaries.
// Notes: Threshold code width and memory depth are module parameters.
package aiss_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int GAP_W = 16;
    localparam int SCAN_W = 24;
    localparam int CNT_W = 24;
    localparam int CHAN_W = 6;
    localparam int GAIN_W = 3;
    localparam int ENT_W = 11;
    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_CMD = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_MODE = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_GAP = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_SCAN = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_PRE = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_POST = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_THI = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_TLO = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_CADDR = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_CDATA = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_CLAST = 6'h28;
    localparam logic [ADDR_W-1:0] OFS_STAT = 6'h2C;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 6'h30;
    // Command strobe bits.
    localparam int CMD_ARM = 0;
    localparam int CMD_DISARM = 1;
    localparam int CMD_FIRST_TRIGGER = 2;
    localparam int CMD_SECOND_TRIGGER = 3;
    // Mode register fields.
    localparam int MODE_ACQ = 0;
    localparam int MODE_RETRIG = 2;
    localparam int MODE_ASRC = 3;
    localparam int MODE_ATYPE = 4;
    localparam int MODE_T1_ANA = 6;
    localparam int MODE_T2_ANA = 7;
    localparam int MODE_PFI0_OE = 8;
    localparam int MODE_PFI1_OE = 9;
    localparam int MODE_W = 10;
    localparam logic [1:0] ACQ_POST = 2'h0;
    localparam logic [1:0] ACQ_PRE = 2'h1;
    localparam logic [1:0] ACQ_CONT = 2'h2;
    localparam logic [1:0] AT_ABOVE = 2'h0;
    localparam logic [1:0] AT_BELOW = 2'h1;
    localparam logic [1:0] AT_RISE = 2'h2;
    localparam logic [1:0] AT_FALL = 2'h3;
    // Entry fields of the configuration memory.
    localparam int ENT_CHAN = 0;
    localparam int ENT_GAIN = 6;
    localparam int ENT_DISC = 9;
    localparam int ENT_EOS = 10;
    // Reset values and timing.
    localparam logic [GAP_W-1:0] GAP_RST = 16'h0002;
    localparam logic [GAP_W-1:0] GAP_MIN = 16'h0002;
    localparam logic [SCAN_W-1:0] SCAN_RST = 24'h000010;
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
    localparam logic [3:0] THR_HALF = 4'h4;
    typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN} aiss_state_t;
endpackage : aiss_pkg

// file: common/aiss_cfg_if.sv
// Purpose: Port bundle between the sequencer and its configuration memory.
// Assumes: One write port and one registered read port.
// Notes: Read data follow the read address by one clock.
`timescale 1ns/100ps
interface aiss_cfg_if #(parameter int PTR_W = 6, parameter int ENT_W = 11);
    logic wr_en;
    logic [PTR_W-1:0] wr_addr;
    logic [ENT_W-1:0] wr_data;
    logic [PTR_W-1:0] rd_addr;
    logic [ENT_W-1:0] rd_data;
    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : aiss_cfg_if

// file: rtl/aiss_cfg_mem.sv
// Purpose: Configuration memory holding one entry per conversion.
// Assumes: Single clock, write and read may address the same word.
// Notes: Read data come from a register one clock after the address.
`timescale 1ns/100ps
module aiss_cfg_mem #(
    parameter int DEPTH = 64,
    parameter int PTR_W = 6,
    parameter int ENT_W = 11
) (
    input wire logic mclk,
    input wire logic rst_b,
    aiss_cfg_if.mem cfg
);
    logic [ENT_W-1:0] mem_q [DEPTH];
    logic [ENT_W-1:0] rd_q;

    // Software writes entries; the array has no reset.
    always_ff @(posedge mclk) begin
        if (cfg.wr_en) begin
            mem_q[cfg.wr_addr] <= cfg.wr_data;
        end
    end

    // Registered read port.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem_q[cfg.rd_addr];
        end
    end

    assign cfg.rd_data = rd_q;
endmodule : aiss_cfg_mem

// file: rtl/aiss_seq.sv
// Purpose: Scan sequencer for analog input acquisition with trigger control.
// Assumes: Converter done, comparators and trigger pin are asynchronous.
// Notes: Minimum spacing between conversions is two clocks.
`timescale 1ns/100ps
// Summary of operation
// - Convert pulse whenever the sample gap counter reaches terminal count.
// - Scan interval terminal count gives scan start, which starts convert pulses.
// - Sample gap counter 16 bits; scan interval and length counters 24 bits.
// - The conversion with end-of-scan flag set ends the scan.
// - Scan begins on start, entries applied in order, stop pulse ends it.
// - Pointer runs past end-of-scan, wraps from last entry to first.
// - Discard entries convert but write nothing into the sample FIFO.
// - Normally acquisition ends when the length counter counts to zero.
// - Acquisition starts from a software strobe or an external trigger.
// - First and second trigger each appear on their own function pin.
// - Posttrigger: armed, wait for first trigger, acquire until counter zero.
// - Pretrigger: load pretrigger count, start on strobe or first trigger.
// - Pretrigger zero: keep scanning, counter holds, loads posttrigger count.
// - Second trigger resumes counting from posttrigger count; zero ends it.
// - Retriggerable: reload and await first trigger again until disabled.
// - Continuous: reload the counter at every zero, running indefinitely.
// - Disarming stops continuous acquisition at the counter's next zero.
// - Source select chooses pin zero or gain-adjusted channel for comparison.
// - High and low thresholds loaded serially, 8 or 12 bit codes.
// - Comparator outputs are analog triggers routable to internal trigger lines.
// - Analog trigger on rising slope, falling slope or absolute level.
module aiss_seq #(
    parameter int DEPTH = 64,
    parameter int PTR_W = 6,
    parameter int CODE_W = 12
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [aiss_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [aiss_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [aiss_pkg::DATA_W-1:0] reg_rdata,
    output logic convert_o,
    output logic scan_start_o,
    output logic scan_stop_o,
    output logic [aiss_pkg::CHAN_W-1:0] mux_chan_o,
    output logic [aiss_pkg::GAIN_W-1:0] gain_o,
    input wire logic adc_done_i,
    output logic fifo_wr_o,
    input wire logic cmp_hi_i,
    input wire logic cmp_lo_i,
    output logic analog_trigger_source_select,
    output logic thr_sclk_o,
    output logic thr_sdata_o,
    output logic thr_cs_hi_b_o,
    output logic thr_cs_lo_b_o,
    input wire logic pfi0_i,
    output logic pfi0_o,
    output logic pfi0_oe,
    input wire logic pfi1_i,
    output logic pfi1_o,
    output logic pfi1_oe
);
    aiss_pkg::aiss_state_t state_q;
    logic [aiss_pkg::MODE_W-1:0] mode_q;
    logic [aiss_pkg::GAP_W-1:0] gap_iv_q, gap_q;
    logic [aiss_pkg::SCAN_W-1:0] scan_iv_q, si_q;
    logic [aiss_pkg::CNT_W-1:0] pre_q, post_q, cnt_q;
    logic [CODE_W-1:0] thi_q, tlo_q, sh_q;
    logic [PTR_W-1:0] caddr_q, last_q, ptr_q;
    logic pend_hi_q, pend_lo_q, busy_q, sel_hi_q, sclk_q;
    logic [3:0] div_q;
    logic [4:0] bits_q;
    logic in_scan_q, wait2_q, phase2_q, dis_q, drise, disc_old;
    logic [3:0] dq_q;
    logic [2:0] dn_q;
    logic [2:0] done_s_q, hi_s_q, lo_s_q, p0_s_q, p1_s_q;
    logic acond_q, slope_q, atrig, cond;
    logic wr_cmd, arm, disarm, trig1, trig2, run, conv, zero;
    logic [1:0] acq;
    logic [aiss_pkg::ENT_W-1:0] ent;

    aiss_cfg_if #(.PTR_W(PTR_W), .ENT_W(aiss_pkg::ENT_W)) cfg ();
    aiss_cfg_mem #(.DEPTH(DEPTH), .PTR_W(PTR_W), .ENT_W(aiss_pkg::ENT_W)) u_mem (
        .mclk(mclk),
        .rst_b(rst_b),
        .cfg(cfg)
    );

    // Command strobes and decoded controls.
    assign wr_cmd = reg_wr && (reg_addr == aiss_pkg::OFS_CMD);
    assign arm = wr_cmd && reg_wdata[aiss_pkg::CMD_ARM];
    assign disarm = wr_cmd && reg_wdata[aiss_pkg::CMD_DISARM];
    assign acq = mode_q[aiss_pkg::MODE_ACQ +: 2];
    assign run = (state_q == aiss_pkg::S_RUN);
    assign ent = cfg.rd_data;
    assign analog_trigger_source_select = mode_q[aiss_pkg::MODE_ASRC];

    // Software writes to configuration registers.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= '0;
            gap_iv_q <= aiss_pkg::GAP_RST;
            scan_iv_q <= aiss_pkg::SCAN_RST;
            pre_q <= aiss_pkg::CNT_ONE;
            post_q <= aiss_pkg::CNT_ONE;
            thi_q <= '0;
            tlo_q <= '0;
            caddr_q <= '0;
            last_q <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                aiss_pkg::OFS_MODE: mode_q <= reg_wdata[aiss_pkg::MODE_W-1:0];
                aiss_pkg::OFS_GAP: gap_iv_q <= reg_wdata[aiss_pkg::GAP_W-1:0];
                aiss_pkg::OFS_SCAN: scan_iv_q <= reg_wdata[aiss_pkg::SCAN_W-1:0];
                aiss_pkg::OFS_PRE: pre_q <= reg_wdata[aiss_pkg::CNT_W-1:0];
                aiss_pkg::OFS_POST: post_q <= reg_wdata[aiss_pkg::CNT_W-1:0];
                aiss_pkg::OFS_THI: thi_q <= reg_wdata[CODE_W-1:0];
                aiss_pkg::OFS_TLO: tlo_q <= reg_wdata[CODE_W-1:0];
                aiss_pkg::OFS_CADDR: caddr_q <= reg_wdata[PTR_W-1:0];
                aiss_pkg::OFS_CDATA: caddr_q <= caddr_q + 1'b1;
                aiss_pkg::OFS_CLAST: last_q <= reg_wdata[PTR_W-1:0];
                default: ;
            endcase
        end
    end

    // Entry writes go to the memory; the sequencer reads at the pointer.
    assign cfg.wr_en = reg_wr && (reg_addr == aiss_pkg::OFS_CDATA);
    assign cfg.wr_addr = caddr_q;
    assign cfg.wr_data = reg_wdata[aiss_pkg::ENT_W-1:0];
    assign cfg.rd_addr = ptr_q;

    // Read data stand in the cycle after the read strobe.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                aiss_pkg::OFS_MODE: reg_rdata <= 32'(mode_q);
                aiss_pkg::OFS_GAP: reg_rdata <= 32'(gap_iv_q);
                aiss_pkg::OFS_SCAN: reg_rdata <= 32'(scan_iv_q);
                aiss_pkg::OFS_PRE: reg_rdata <= 32'(pre_q);
                aiss_pkg::OFS_POST: reg_rdata <= 32'(post_q);
                aiss_pkg::OFS_CADDR: reg_rdata <= 32'(caddr_q);
                aiss_pkg::OFS_CLAST: reg_rdata <= 32'(last_q);
                aiss_pkg::OFS_STAT: reg_rdata <= 32'({busy_q, phase2_q, wait2_q, in_scan_q,
                                                      dis_q, state_q, ptr_q});
                aiss_pkg::OFS_COUNT: reg_rdata <= 32'(cnt_q);
                default: reg_rdata <= '0;
            endcase
        end
    end

    // Two-stage synchronisers plus one history stage for edge detection.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            done_s_q <= '0;
            hi_s_q <= '0;
            lo_s_q <= '0;
            p0_s_q <= '0;
            p1_s_q <= '0;
        end else begin
            done_s_q <= {done_s_q[1:0], adc_done_i};
            hi_s_q <= {hi_s_q[1:0], cmp_hi_i};
            lo_s_q <= {lo_s_q[1:0], cmp_lo_i};
            p0_s_q <= {p0_s_q[1:0], pfi0_i};
            p1_s_q <= {p1_s_q[1:0], pfi1_i};
        end
    end

    // Analog trigger: level types fire when the condition becomes true; slope types
    // must first see the opposite threshold, which gives hysteresis against noise.
    always_comb begin
        case (mode_q[aiss_pkg::MODE_ATYPE +: 2])
            aiss_pkg::AT_ABOVE: cond = hi_s_q[1];
            aiss_pkg::AT_BELOW: cond = !lo_s_q[1];
            aiss_pkg::AT_RISE: cond = hi_s_q[1] && slope_q;
            default: cond = !lo_s_q[1] && slope_q;
        endcase
    end
    assign atrig = cond && !acond_q;

    // Slope arming and condition history.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acond_q <= 1'b0;
            slope_q <= 1'b0;
        end else begin
            acond_q <= cond;
            if (mode_q[aiss_pkg::MODE_ATYPE +: 2] == aiss_pkg::AT_RISE) begin
                slope_q <= hi_s_q[1] ? 1'b0 : (!lo_s_q[1] ? 1'b1 : slope_q);
            end else begin
                slope_q <= !lo_s_q[1] ? 1'b0 : (hi_s_q[1] ? 1'b1 : slope_q);
            end
        end
    end

    // Trigger sources: software strobe, pin edge, or routed analog trigger.
    assign trig1 = (wr_cmd && reg_wdata[aiss_pkg::CMD_FIRST_TRIGGER])
        || (mode_q[aiss_pkg::MODE_T1_ANA] ? atrig : (!mode_q[aiss_pkg::MODE_PFI0_OE]
        && p0_s_q[1] && !p0_s_q[2]));
    assign trig2 = (wr_cmd && reg_wdata[aiss_pkg::CMD_SECOND_TRIGGER])
        || (mode_q[aiss_pkg::MODE_T2_ANA] ? atrig : (!mode_q[aiss_pkg::MODE_PFI1_OE]
        && p1_s_q[1] && !p1_s_q[2]));

    // Function pins carry the internal trigger lines out when enabled.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pfi0_o <= 1'b0;
            pfi1_o <= 1'b0;
        end else begin
            pfi0_o <= trig1;
            pfi1_o <= trig2;
        end
    end
    assign pfi0_oe = mode_q[aiss_pkg::MODE_PFI0_OE];
    assign pfi1_oe = mode_q[aiss_pkg::MODE_PFI1_OE];

    // Scan interval counter: terminal count at zero starts a scan, unless a scan is in progress or a disarm ends the run.
    assign scan_start_o = run && (si_q == '0) && !in_scan_q && !(wait2_q && disarm);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            si_q <= '0;
        end else if (!run || si_q == '0) begin
            si_q <= run ? scan_iv_q - 1'b1 : '0;
        end else begin
            si_q <= si_q - 1'b1;
        end
    end

    // Sample gap counter and scan framing.
    assign conv = in_scan_q && (gap_q == '0);
    assign convert_o = conv;
    assign scan_stop_o = conv && ent[aiss_pkg::ENT_EOS];
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            in_scan_q <= 1'b0;
            gap_q <= '0;
        end else if (!run || (wait2_q && disarm)) begin
            in_scan_q <= 1'b0;
            gap_q <= '0;
        end else if (scan_start_o) begin
            in_scan_q <= 1'b1;
            gap_q <= '0;
        end else if (conv) begin
            in_scan_q <= !ent[aiss_pkg::ENT_EOS];
            gap_q <= (gap_iv_q < aiss_pkg::GAP_MIN) ? aiss_pkg::GAP_MIN - 1'b1
                : gap_iv_q - 1'b1;
        end else if (in_scan_q) begin
            gap_q <= gap_q - 1'b1;
        end
    end

    // Entry pointer steps once per conversion and wraps after the last entry.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= '0;
        end else if (arm && state_q == aiss_pkg::S_IDLE) begin
            ptr_q <= '0;
        end else if (conv) begin
            ptr_q <= (ptr_q == last_q) ? '0 : ptr_q + 1'b1;
        end
    end

    // Channel and gain of the entry in conversion.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mux_chan_o <= '0;
            gain_o <= '0;
        end else if (conv) begin
            mux_chan_o <= ent[aiss_pkg::ENT_CHAN +: aiss_pkg::CHAN_W];
            gain_o <= ent[aiss_pkg::ENT_GAIN +: aiss_pkg::GAIN_W];
        end
    end

    // Discard flags of conversions in flight, newest in bit zero; results return in order,
    // so each done edge takes the oldest flag even with a short gap (four in flight at most).
    assign drise = done_s_q[1] && !done_s_q[2];
    assign disc_old = dq_q[2'(dn_q - 1'b1)];
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dq_q <= '0;
            dn_q <= '0;
            fifo_wr_o <= 1'b0;
        end else begin
            if (conv) begin
                dq_q <= {dq_q[2:0], ent[aiss_pkg::ENT_DISC]};
            end
            dn_q <= dn_q + 3'(conv) - 3'(drise && dn_q != '0);
            fifo_wr_o <= drise && !disc_old;
        end
    end

    // Acquisition level control: arming, counting, reload and ending.
    assign zero = scan_stop_o && !wait2_q && (cnt_q == aiss_pkg::CNT_ONE);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= aiss_pkg::S_IDLE;
            cnt_q <= '0;
            wait2_q <= 1'b0;
            phase2_q <= 1'b0;
            dis_q <= 1'b0;
        end else begin
            if (disarm) begin
                dis_q <= 1'b1;
            end else if (arm) begin
                dis_q <= 1'b0;
            end
            case (state_q)
                aiss_pkg::S_IDLE: if (arm) begin
                    cnt_q <= pre_q;
                    wait2_q <= 1'b0;
                    phase2_q <= 1'b0;
                    state_q <= aiss_pkg::S_ARMED;
                end
                aiss_pkg::S_ARMED: if (disarm) begin
                    state_q <= aiss_pkg::S_IDLE;
                end else if (trig1) begin
                    state_q <= aiss_pkg::S_RUN;
                end
                aiss_pkg::S_RUN: if (wait2_q && disarm) begin
                    state_q <= aiss_pkg::S_IDLE;
                end else if (wait2_q) begin
                    if (trig2) begin
                        wait2_q <= 1'b0;
                        phase2_q <= 1'b1;
                    end
                end else if (zero) begin
                    if (acq == aiss_pkg::ACQ_PRE && !phase2_q) begin
                        wait2_q <= 1'b1;
                        cnt_q <= post_q;
                    end else if (acq == aiss_pkg::ACQ_CONT && !dis_q && !disarm) begin
                        cnt_q <= pre_q;
                    end else if (mode_q[aiss_pkg::MODE_RETRIG] && !dis_q && !disarm) begin
                        cnt_q <= pre_q;
                        phase2_q <= 1'b0;
                        state_q <= aiss_pkg::S_ARMED;
                    end else begin
                        state_q <= aiss_pkg::S_IDLE;
                    end
                end else if (scan_stop_o) begin
                    cnt_q <= cnt_q - 1'b1;
                end
                default: state_q <= aiss_pkg::S_IDLE;
            endcase
        end
    end

    // Serial threshold loader: high code first, MSB first, data change on falling clock.
    assign thr_sclk_o = sclk_q;
    assign thr_sdata_o = sh_q[CODE_W-1];
    assign thr_cs_hi_b_o = !(busy_q && sel_hi_q);
    assign thr_cs_lo_b_o = !(busy_q && !sel_hi_q);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pend_hi_q <= 1'b0;
            pend_lo_q <= 1'b0;
            busy_q <= 1'b0;
            sel_hi_q <= 1'b0;
            sclk_q <= 1'b0;
            sh_q <= '0;
            div_q <= '0;
            bits_q <= '0;
        end else begin
            if (!busy_q && (pend_hi_q || pend_lo_q)) begin
                busy_q <= 1'b1;
                sel_hi_q <= pend_hi_q;
                sh_q <= pend_hi_q ? thi_q : tlo_q;
                bits_q <= 5'(CODE_W);
                div_q <= aiss_pkg::THR_HALF;
            end else if (busy_q && div_q != '0) begin
                div_q <= div_q - 1'b1;
            end else if (busy_q) begin
                div_q <= aiss_pkg::THR_HALF;
                sclk_q <= !sclk_q;
                if (sclk_q) begin
                    sh_q <= sh_q << 1;
                    bits_q <= bits_q - 1'b1;
                    busy_q <= (bits_q != 5'h01);
                end
            end
            // A new write wins over the pending flag being taken.
            pend_hi_q <= (reg_wr && reg_addr == aiss_pkg::OFS_THI)
                || (pend_hi_q && !(!busy_q));
            pend_lo_q <= (reg_wr && reg_addr == aiss_pkg::OFS_TLO)
                || (pend_lo_q && !(!busy_q && !pend_hi_q));
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Checks on the sequencing behaviour.
    a_conv_spacing: assert property (conv |=> !conv) else $error("convert too close");
    a_start_conv: assert property (scan_start_o |=> conv) else $error("no convert");
    a_eos_stop: assert property (scan_stop_o |=> !in_scan_q) else $error("scan kept");
    a_ptr_wrap: assert property (conv && ptr_q == last_q |=> ptr_q == '0)
        else $error("pointer did not wrap");
    a_discard_drop: assert property (disc_old && drise |=> !fifo_wr_o)
        else $error("discarded sample written");
    a_armed_wait: assert property (state_q == aiss_pkg::S_ARMED && !trig1 |=> !run)
        else $error("ran without trigger");
    a_pre_hold: assert property (wait2_q && !trig2 && run |=> $stable(cnt_q))
        else $error("counter moved while waiting");
    a_pre_load: assert property (zero && acq == aiss_pkg::ACQ_PRE && !phase2_q
        |=> wait2_q && cnt_q == $past(post_q)) else $error("post count not loaded");
    a_cont_reload: assert property (zero && acq == aiss_pkg::ACQ_CONT && !dis_q && !disarm
        |=> run && cnt_q == $past(pre_q)) else $error("no reload");
    a_idle_quiet: assert property (!run |-> !convert_o) else $error("convert idle");
    c_pre_wait: cover property (wait2_q ##1 !wait2_q && phase2_q);
    c_retrig: cover property (zero && mode_q[aiss_pkg::MODE_RETRIG] ##1 !run);
    c_wrap: cover property (conv && ptr_q == last_q);
endmodule : aiss_seq

// file: sim/aiss_adc_model.sv
// Purpose: Converter model answering each convert pulse, plus a high threshold receiver.
// Assumes: Conversion takes three clocks, done stays high two clocks.
// Notes: Done is low between conversions three or more clocks apart, so every rise is then a fresh result.
`timescale 1ns/100ps
module aiss_adc_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic convert_i,
    output logic done_o,
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic cs_b_i,
    output logic [11:0] code_o
);
    logic [4:0] pipe_q;
    // Delays the convert pulse and stretches it into a done pulse.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pipe_q <= 5'h00;
        end else begin
            pipe_q <= {pipe_q[3:0], convert_i};
        end
    end
    assign done_o = pipe_q[2] | pipe_q[3];
    // Threshold converter takes data MSB first on the rising serial clock while selected.
    always_ff @(posedge sclk_i) begin
        if (!cs_b_i) begin
            code_o <= {code_o[10:0], sdata_i};
        end
    end
endmodule : aiss_adc_model

// file: sim/aiss_seq_test.sv
// Purpose: Self-checking bench for the scan sequencer.
// Assumes: Converter model in place; comparators and second pin idle low.
// Notes: Pulses on the converter side are counted by a monitor.
`timescale 1ns/100ps
module aiss_seq_test;
    logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, pfi0_i = 0, adc_done;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, st;
    logic convert_o, scan_stop_o, fifo_wr_o, asel, p0o, thr_sclk, thr_sdata, thr_cs_hi_b;
    logic [11:0] thr_hi;
    logic [5:0] chan;
    logic [2:0] gain;
    int errors = 0, checks = 0, nconv = 0, nwr = 0, nstop = 0, cyc = 0, np0 = 0;
    always #2 mclk = ~mclk;
    aiss_seq DUT (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .convert_o, .scan_start_o(), .scan_stop_o, .mux_chan_o(chan), .gain_o(gain),
        .adc_done_i(adc_done), .fifo_wr_o, .cmp_hi_i(1'b0), .cmp_lo_i(1'b0),
        .analog_trigger_source_select(asel), .thr_sclk_o(thr_sclk), .thr_sdata_o(thr_sdata),
        .thr_cs_hi_b_o(thr_cs_hi_b), .thr_cs_lo_b_o(), .pfi0_i, .pfi0_o(p0o), .pfi0_oe(),
        .pfi1_i(1'b0), .pfi1_o(), .pfi1_oe());
    aiss_adc_model ADC (.mclk, .rst_b, .convert_i(convert_o), .done_o(adc_done),
        .sclk_i(thr_sclk), .sdata_i(thr_sdata), .cs_b_i(thr_cs_hi_b), .code_o(thr_hi));
    // Counts converter-side pulses and cuts a hang short.
    always @(posedge mclk) begin
        cyc++;
        nconv += convert_o;
        nwr += fifo_wr_o;
        nstop += scan_stop_o;
        np0 += p0o;
        if (cyc == 20000) begin
            errors++;
            final_report;
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge mclk);
        reg_wr <= 0;
    endtask : wr
    task rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge mclk);
        reg_rd <= 0;
        #1 v = reg_rdata;
    endtask : rd
    task wait_idle;
        for (int i = 0; i < 400; i++) begin
            rd(aiss_pkg::OFS_STAT, st);
            if (st[7:6] === 2'h0) break;
        end
    endtask : wait_idle
    task test_reset;
        rd(aiss_pkg::OFS_GAP, st); chk("gap", 32'h2, st);
        rd(aiss_pkg::OFS_SCAN, st); chk("scan", 32'h10, st);
        rd(aiss_pkg::OFS_STAT, st); chk("status", 32'h0, st);
        rd(6'h3C, st); chk("unmapped", 32'h0, st);
        $display("test reset done");
    endtask : test_reset
    task test_post_pin;
        wr(aiss_pkg::OFS_CADDR, 32'h0);
        wr(aiss_pkg::OFS_CDATA, 32'h045);
        wr(aiss_pkg::OFS_CDATA, 32'h683);
        wr(aiss_pkg::OFS_CLAST, 32'h1);
        wr(aiss_pkg::OFS_GAP, 32'h8);
        wr(aiss_pkg::OFS_SCAN, 32'h20);
        wr(aiss_pkg::OFS_PRE, 32'h2);
        wr(aiss_pkg::OFS_CMD, 32'h1);
        nconv = 0; nwr = 0; nstop = 0;
        np0 = 0;
        repeat (10) @(posedge mclk);
        chk("convert before trigger", 32'h0, nconv);
        pfi0_i <= 1;
        wait_idle;
        repeat (20) @(posedge mclk);
        chk("converts", 32'h4, nconv);
        chk("stops", 32'h2, nstop);
        chk("fifo writes", 32'h2, nwr);
        chk("pin out", 32'h1, np0);
        chk("channel", 32'h3, chan);
        chk("gain", 32'h2, gain);
        pfi0_i <= 0;
        $display("test post_pin done");
    endtask : test_post_pin
    task test_cont;
        wr(aiss_pkg::OFS_MODE, 32'h2);
        wr(aiss_pkg::OFS_PRE, 32'h1);
        wr(aiss_pkg::OFS_CMD, 32'h1);
        wr(aiss_pkg::OFS_CMD, 32'h4);
        nstop = 0;
        repeat (200) @(posedge mclk);
        rd(aiss_pkg::OFS_STAT, st);
        chk("running", 32'h2, st[7:6]);
        chk("several scans", 32'h1, nstop > 3);
        wr(aiss_pkg::OFS_CMD, 32'h2);
        wait_idle;
        chk("stopped", 32'h0, st[7:6]);
        $display("test cont done");
    endtask : test_cont
    task test_pre;
        wr(aiss_pkg::OFS_MODE, 32'h9);
        wr(aiss_pkg::OFS_POST, 32'h2);
        wr(aiss_pkg::OFS_CMD, 32'h1);
        chk("source select", 32'h1, asel);
        rd(aiss_pkg::OFS_COUNT, st); chk("pre count", 32'h1, st);
        wr(aiss_pkg::OFS_CMD, 32'h4);
        repeat (150) @(posedge mclk);
        rd(aiss_pkg::OFS_STAT, st);
        chk("pre running", 32'h2, st[7:6]);
        chk("wait second", 32'h1, st[10]);
        rd(aiss_pkg::OFS_COUNT, st); chk("post count", 32'h2, st);
        wr(aiss_pkg::OFS_CMD, 32'h8);
        wait_idle;
        chk("pre stopped", 32'h0, st[7:6]);
        $display("test pre done");
    endtask : test_pre
    task test_thr;
        wr(aiss_pkg::OFS_THI, 32'hA5C);
        repeat (150) @(posedge mclk);
        chk("high threshold", 32'hA5C, thr_hi);
        $display("test thr done");
    endtask : test_thr
    task final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // Holds reset for eight clocks, then runs every test in turn.
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1;
        test_reset;
        test_post_pin;
        test_cont;
        test_pre;
        test_thr;
        final_report;
    end
endmodule : aiss_seq_test
